// ==== dv/tb.sv ====
// self-checking bench for the up/down reload timer, driving AXI4-Lite and pins
// assumes udt_consts.svh and udt_pkg are compiled ahead of this file
`timescale 1ns/1ps
`include "udt_consts.svh"
module tb;
  // clock, reset, bus and pins
  logic core_clk, resetn;
  logic awv, awr, wv, wr_rdy, bv, bry, arv, arr, rv, rry;
  logic [3:0] awa, ara, wst;
  logic [31:0] wd, rdat, v;
  logic [1:0] brsp, rrsp, rsp;
  logic evp, esel, udp, subm, irq;
  logic [12:0] dv;
  int n_errors, tests_run, i;
  // entries: mode, {flag, pin}, start, value after two events
  logic [31:0] tbl [6] = '{32'h278101FF, 32'h4701100E, 32'h47001012,
    32'h67001012, 32'h8781FEFE, 32'hA7810101};
  // entries: clock code, sub mode, low bound, high bound
  logic [31:0] tps [5] = '{32'h03000306, 32'h04000F12, 32'h05003F42,
    32'h05010000, 32'h06010F12};

  udt_timer uut (.core_clk_i(core_clk), .resetn_i(resetn), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy),
    .s_axi_wdata(wd), .s_axi_wstrb(wst), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_bresp(brsp), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
    .s_axi_rvalid(rv), .s_axi_rready(rry), .s_axi_rdata(rdat), .s_axi_rresp(rrsp),
    .presc_tap_i({dv[1], dv[3], dv[5], dv[8], dv[10], dv[12]}), .sub_clk_div4_i(dv[3]),
    .event_input_pin_i(evp), .event_edge_select_i(esel), .up_down_pin_i(udp),
    .sub_mode_i(subm), .irq_o(irq));

  // clock and a free divider standing in for the prescaler taps
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk) dv <= resetn ? dv + 13'h0001 : 13'h0000;

  task automatic test_done;
    $display("tests %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // bounded wait: a hung handshake ends the run
  task automatic tick_or_quit(inout int k);
    @(posedge core_clk);
    k++;
    if (k > 50)
    begin
      chk(32'h0, 32'h1);
      test_done();
    end
  endtask

  // address and data offered together, each released once taken
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge core_clk);
    awv <= 1'b1;
    awa <= a;
    wv <= 1'b1;
    wd <= {24'h000000, d};
    bry <= 1'b1;
    do
    begin
      tick_or_quit(k);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr_rdy) wv <= 1'b0;
    end
    while (!bv);
    rsp = brsp;
    bry <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    int k;
    k = 0;
    @(posedge core_clk);
    arv <= 1'b1;
    ara <= a;
    rry <= 1'b1;
    do
    begin
      tick_or_quit(k);
      if (arv && arr) arv <= 1'b0;
    end
    while (!rv);
    d = rdat;
    rsp = rrsp;
    rry <= 1'b0;
  endtask

  // n high pulses on the event pin, each long enough for the synchroniser
  task automatic ev(input int n);
    repeat (n)
    begin
      @(posedge core_clk) evp <= 1'b1;
      repeat (5) @(posedge core_clk);
      evp <= 1'b0;
      repeat (5) @(posedge core_clk);
    end
  endtask

  // main sequence
  initial
  begin
    {resetn, awv, wv, bry, arv, rry, evp, udp, subm} = '0;
    {awa, ara, wd} = '0;
    wst = 4'hF;
    esel = 1'b1;
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    rd(`UDT_OFS_MODE, v); chk(v, 32'h18);
    rd(`UDT_OFS_COUNT, v); chk(v, 32'h0);
    chk({31'h0, irq}, 32'h0);
    $display("test reset done");
    // event pin counting up through the wrap; the interrupt stays off until the mask enables it
    wr(`UDT_OFS_MODE, 8'h07);
    rd(`UDT_OFS_MODE, v); chk(v, 32'h1F);
    wr(`UDT_OFS_COUNT, 8'hFE); rd(`UDT_OFS_COUNT, v); chk(v, 32'hFE);
    ev(1); rd(`UDT_OFS_COUNT, v); chk(v, 32'hFF);
    ev(1); rd(`UDT_OFS_COUNT, v); chk(v, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(`UDT_OFS_MASK, 8'h01); chk({31'h0, irq}, 32'h1);
    rd(`UDT_OFS_STATUS, v); chk(v, 32'h1);
    chk({31'h0, irq}, 32'h0);
    $display("test interval up done");
    // direction modes and auto-reload, two events each
    for (i = 0; i < 6; i++)
    begin
      wr(`UDT_OFS_MODE, tbl[i][31:24]);
      udp <= tbl[i][16];
      wr(`UDT_OFS_COUNT, tbl[i][15:8]);
      ev(2);
      rd(`UDT_OFS_COUNT, v); chk(v, {24'h0, tbl[i][7:0]});
      chk({31'h0, irq}, {31'h0, tbl[i][23]});
      rd(`UDT_OFS_STATUS, v); chk(v, {31'h0, tbl[i][23]});
    end
    $display("test direction and reload done");
    // falling edge selected: the rising edge must not count
    esel <= 1'b0;
    wr(`UDT_OFS_MODE, 8'h07);
    wr(`UDT_OFS_COUNT, 8'h20);
    evp <= 1'b1;
    repeat (8) @(posedge core_clk);
    rd(`UDT_OFS_COUNT, v); chk(v, 32'h20);
    evp <= 1'b0;
    repeat (8) @(posedge core_clk);
    rd(`UDT_OFS_COUNT, v); chk(v, 32'h21);
    $display("test falling edge done");
    // tap rates over 256 cycles, with sub mode holding the divide-by-4 tap and running the sub-clock source
    for (i = 0; i < 5; i++)
    begin
      subm <= tps[i][16];
      wr(`UDT_OFS_MODE, tps[i][31:24]);
      wr(`UDT_OFS_COUNT, 8'h00);
      repeat (256) @(posedge core_clk);
      rd(`UDT_OFS_COUNT, v);
      chk({31'h0, (v >= tps[i][15:8] && v <= tps[i][7:0])}, 32'h1);
    end
    subm <= 1'b0;
    $display("test clock sources done");
    rd(4'h2, v); chk({30'h0, rsp}, {30'h0, `UDT_RESP_ERR});
    chk(v, 32'h0);
    wr(4'h6, 8'h55); chk({30'h0, rsp}, {30'h0, `UDT_RESP_ERR});
    $display("test unmapped done");
    test_done();
  end
endmodule

// ==== rtl/udt_consts.svh ====
// constants for the up/down reload timer: offsets, fields, reset values
// assumes a 32-bit AXI4-Lite slave with one aligned word per register
`ifndef UDT_CONSTS_SVH
`define UDT_CONSTS_SVH
// register byte offsets
`define UDT_OFS_MODE 4'h0
`define UDT_OFS_COUNT 4'h4
`define UDT_OFS_STATUS 4'h8
`define UDT_OFS_MASK 4'hC
// mode register fields
`define UDT_BIT_RELOAD 7
`define UDT_BIT_HWDIR 6
`define UDT_BIT_SWDIR 5
`define UDT_CSEL_MSB 2
`define UDT_CSEL_LSB 0
`define UDT_MODE_WMASK 8'hE7
`define UDT_MODE_RSVD 8'h18
// reset values
`define UDT_MODE_RST 8'h18
`define UDT_COUNT_RST 8'h00
`define UDT_RELOAD_RST 8'h00
// counter limits
`define UDT_TOP 8'hFF
`define UDT_BOTTOM 8'h00
// number of system prescaler taps
`define UDT_NTAPS 6
// bus responses
`define UDT_RESP_OK 2'h0
`define UDT_RESP_ERR 2'h2
`endif

// ==== rtl/udt_pkg.sv ====
// types for the up/down reload timer
// assumes udt_consts.svh supplies the numeric constants
package udt_pkg;
  // counter clock source codes
  typedef enum logic [2:0] {
    UDT_CS_DIV8192 = 3'b000,
    UDT_CS_DIV2048 = 3'b001,
    UDT_CS_DIV512 = 3'b010,
    UDT_CS_DIV64 = 3'b011,
    UDT_CS_DIV16 = 3'b100,
    UDT_CS_DIV4 = 3'b101,
    UDT_CS_SUB4 = 3'b110,
    UDT_CS_EVENT = 3'b111
  } udt_clksel_t;
  // register selected by a bus address
  typedef enum logic [2:0] {
    UDT_REG_MODE = 3'b000,
    UDT_REG_COUNT = 3'b001,
    UDT_REG_STATUS = 3'b010,
    UDT_REG_MASK = 3'b011,
    UDT_REG_NONE = 3'b100
  } udt_reg_t;
endpackage

// ==== rtl/udt_timer.sv ====
// 8-bit up/down interval and auto-reload timer with AXI4-Lite registers
// assumes prescaler taps arrive as square waves from an outside divider
`timescale 1ns/1ps
`include "udt_consts.svh"
module udt_timer
  import udt_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // write address channel
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [3:0] s_axi_awaddr,
  // write data channel
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // write response channel
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // read address channel
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [3:0] s_axi_araddr,
  // read data channel
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // clock sources
  input wire logic [5:0] presc_tap_i,
  input wire logic sub_clk_div4_i,
  // pins and outside controls
  input wire logic event_input_pin_i,
  input wire logic event_edge_select_i,
  input wire logic up_down_pin_i,
  input wire logic sub_mode_i,
  // interrupt
  output logic irq_o
);

  // shared decode for read and write addresses
  function automatic udt_reg_t addr_sel(input logic [3:0] a);
    udt_reg_t r;
    r = UDT_REG_NONE;
    if (a == `UDT_OFS_MODE)
      r = UDT_REG_MODE;
    else if (a == `UDT_OFS_COUNT)
      r = UDT_REG_COUNT;
    else if (a == `UDT_OFS_STATUS)
      r = UDT_REG_STATUS;
    else if (a == `UDT_OFS_MASK)
      r = UDT_REG_MASK;
    return r;
  endfunction

  logic [7:0] mode;
  logic [7:0] count_value;
  logic [7:0] reload_value;
  logic timer_irq_flag;
  logic timer_irq_enable;
  logic aw_held;
  logic w_held;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_wr;
  logic do_rd;
  udt_reg_t wr_reg;
  udt_reg_t rd_reg;
  logic cnt_wr;
  logic [5:0] tap_q;
  logic [5:0] tap_rise;
  logic ev_s1;
  logic ev_s2;
  logic ev_s3;
  logic sub_s1;
  logic sub_s2;
  logic sub_s3;
  logic ev_edge;
  logic sub_rise;
  logic [1:0] sync_fill;
  udt_clksel_t csel;
  logic tick;
  logic step;
  logic count_down;
  logic at_limit;
  logic wrap;
  logic [7:0] next_count;

  // write channel: address and data taken in either order
  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign do_wr = aw_held && w_held && !s_axi_bvalid;
  assign wr_reg = addr_sel(aw_addr);

  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
    begin
      aw_held <= 1'b0;
      aw_addr <= 4'h0;
    end
    else if (s_axi_awvalid && !aw_held)
    begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end
    else if (do_wr)
      aw_held <= 1'b0;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
    begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end
    else if (s_axi_wvalid && !w_held)
    begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end
    else if (do_wr)
      w_held <= 1'b0;
  end

  // response one cycle after both halves are in
  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `UDT_RESP_OK;
    end
    else if (do_wr)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (wr_reg == UDT_REG_NONE) ? `UDT_RESP_ERR : `UDT_RESP_OK;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // mode register; only byte lane 0 carries data
  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
      mode <= `UDT_MODE_RST;
    else if (do_wr && wr_reg == UDT_REG_MODE && w_strb[0])
      mode <= (w_data[7:0] & `UDT_MODE_WMASK) | `UDT_MODE_RSVD;
  end

  // mask register holding the enable bit
  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
      timer_irq_enable <= 1'b0;
    else if (do_wr && wr_reg == UDT_REG_MASK && w_strb[0])
      timer_irq_enable <= w_data[0];
  end

  // reload shares the counter address; writes land here
  assign cnt_wr = do_wr && wr_reg == UDT_REG_COUNT && w_strb[0];

  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
      reload_value <= `UDT_RELOAD_RST;
    else if (cnt_wr)
      reload_value <= w_data[7:0];
  end

  // read channel, data registered one cycle after the address
  assign s_axi_arready = !s_axi_rvalid;
  assign do_rd = s_axi_arvalid && !s_axi_rvalid;
  assign rd_reg = addr_sel(s_axi_araddr);

  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `UDT_RESP_OK;
    end
    else if (do_rd)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `UDT_RESP_OK;
      if (rd_reg == UDT_REG_MODE)
        s_axi_rdata <= {24'h00_0000, mode | `UDT_MODE_RSVD};
      else if (rd_reg == UDT_REG_COUNT)
        s_axi_rdata <= {24'h00_0000, count_value};
      else if (rd_reg == UDT_REG_STATUS)
        s_axi_rdata <= {31'h0000_0000, timer_irq_flag};
      else if (rd_reg == UDT_REG_MASK)
        s_axi_rdata <= {31'h0000_0000, timer_irq_enable};
      else
      begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `UDT_RESP_ERR;
      end
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // prescaler taps: rising edge of each square wave is one count
  genvar gi;
  generate
    for (gi = 0; gi < `UDT_NTAPS; gi++)
    begin : g_tap
      always_ff @(posedge core_clk_i)
      begin
        if (!resetn_i)
          tap_q[gi] <= 1'b0;
        else
          tap_q[gi] <= presc_tap_i[gi];
      end
      assign tap_rise[gi] = presc_tap_i[gi] && !tap_q[gi] && (sync_fill != 2'b00);
    end
  endgenerate

  // event pin and sub-clock are unrelated to core_clk, so two flops first
  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
    begin
      ev_s1 <= 1'b0;
      ev_s2 <= 1'b0;
      ev_s3 <= 1'b0;
      sub_s1 <= 1'b0;
      sub_s2 <= 1'b0;
      sub_s3 <= 1'b0;
    end
    else
    begin
      ev_s1 <= event_input_pin_i;
      ev_s2 <= ev_s1;
      ev_s3 <= ev_s2;
      sub_s1 <= sub_clk_div4_i;
      sub_s2 <= sub_s1;
      sub_s3 <= sub_s2;
    end
  end

  // edge detectors stay quiet until the chains hold real pin samples,
  // so a pin resting high does not look like an edge just after reset
  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
      sync_fill <= 2'b00;
    else if (sync_fill != 2'b11)
      sync_fill <= sync_fill + 2'b01;
  end

  // edge choice comes from the outside edge-select bit
  assign ev_edge = (sync_fill == 2'b11)
    && (event_edge_select_i ? (ev_s2 && !ev_s3) : (!ev_s2 && ev_s3));
  assign sub_rise = (sync_fill == 2'b11) && sub_s2 && !sub_s3;

  // source select; sub-clock mode keeps only the sub-clock and event sources
  assign csel = udt_clksel_t'(mode[`UDT_CSEL_MSB:`UDT_CSEL_LSB]);

  always_comb
  begin
    tick = 1'b0;
    case (csel)
      UDT_CS_SUB4: tick = sub_rise;
      UDT_CS_EVENT: tick = ev_edge;
      default: tick = tap_rise[csel] && !sub_mode_i;
    endcase
  end

  // direction: pin overrides the software bit when selected
  assign count_down = mode[`UDT_BIT_HWDIR] ? up_down_pin_i : mode[`UDT_BIT_SWDIR];

  // a reload write in the same cycle beats the count step
  assign step = tick && !cnt_wr;
  assign at_limit = count_down ? (count_value == `UDT_BOTTOM) : (count_value == `UDT_TOP);
  assign wrap = step && at_limit;

  always_comb
  begin
    next_count = count_value;
    if (cnt_wr)
      next_count = w_data[7:0];
    else if (wrap && mode[`UDT_BIT_RELOAD])
      next_count = reload_value;
    else if (wrap)
      next_count = count_down ? `UDT_TOP : `UDT_BOTTOM;
    else if (step)
      next_count = count_down ? count_value - 8'h01 : count_value + 8'h01;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
      count_value <= `UDT_COUNT_RST;
    else
      count_value <= next_count;
  end

  // sticky flag: a wrap wins over the clear-on-read
  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
      timer_irq_flag <= 1'b0;
    else if (wrap)
      timer_irq_flag <= 1'b1;
    else if (do_rd && rd_reg == UDT_REG_STATUS)
      timer_irq_flag <= 1'b0;
  end

  // level interrupt, gated by the enable
  assign irq_o = timer_irq_flag && timer_irq_enable;

  // checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);

  a_reload_write: assert property (cnt_wr |=> count_value == $past(w_data[7:0])
    && reload_value == count_value)
    else $error("reload write did not load counter");

  a_up_wrap: assert property (step && !count_down && count_value == 8'hFF
    && !mode[7] |=> count_value == 8'h00 && timer_irq_flag)
    else $error("interval up wrap wrong");

  a_down_wrap: assert property (step && count_down && count_value == 8'h00
    && !mode[7] |=> count_value == 8'hFF && timer_irq_flag)
    else $error("interval down wrap wrong");

  a_auto_reload: assert property (wrap && mode[7] |=>
    count_value == $past(reload_value))
    else $error("auto reload value not loaded");

  a_hw_down: assert property (step && mode[6] && up_down_pin_i
    && count_value != 8'h00 |=> count_value == $past(count_value) - 8'h01)
    else $error("pin high did not count down");

  a_sw_dir: assert property (step && mode[6:5] == 2'b00
    && count_value != 8'hFF |=> count_value == $past(count_value) + 8'h01)
    else $error("software up count wrong");

  a_count_hold: assert property (!tick && !cnt_wr |=> $stable(count_value))
    else $error("counter moved without a tick");

  a_sub_hold: assert property (sub_mode_i && mode[2:1] != 2'b11 |-> !tick)
    else $error("fast source ran in sub-clock mode");

  a_rsvd_bits: assert property (do_rd && rd_reg == UDT_REG_MODE
    |=> s_axi_rdata[4:3] == 2'b11)
    else $error("reserved mode bits not read as one");

  a_irq_gate: assert property ($rose(irq_o) |-> timer_irq_flag
    && timer_irq_enable && ($past(wrap) || $rose(timer_irq_enable)))
    else $error("interrupt without flag and enable");

  a_event_tick: assert property (ev_edge |=> !ev_edge)
    else $error("event edge gave more than one tick");

  c_up_wrap: cover property (wrap && !count_down && !mode[7]);
  c_down_wrap: cover property (wrap && count_down && !mode[7]);
  c_reload: cover property (wrap && mode[7] ##1 count_value != 8'h00);
  c_irq: cover property (irq_o ##1 do_rd && rd_reg == UDT_REG_STATUS);

endmodule
